// ==== common/pci_consts.svh ====
// Constants of the power, command and primary-interface control block.
// Assumes inclusion by bare name from the design file and the bench.
`ifndef PCI_CONSTS_SVH
`define PCI_CONSTS_SVH
// Register offsets (7-bit register address space)
`define PCI_ADR_IF_CONF 7'h6B
`define PCI_ADR_Z_OFFSET 7'h73
`define PCI_ADR_POWER_CONFIGURATION 7'h7C
`define PCI_ADR_SENS_EN 7'h7D
`define PCI_ADR_CMD 7'h7E
// Reset values and command register readback value
`define PCI_RST_IF_CONF 8'h00
`define PCI_RST_Z_OFFSET 8'h00
`define PCI_RST_POWER_CONFIGURATION 8'h03
`define PCI_RST_SENS_EN 8'h00
`define PCI_CMD_READ_VAL 8'h00
// Field positions
`define PCI_BIT_THREE_WIRE 0
`define PCI_BIT_AUX_IF 4
`define PCI_BIT_APS 0
`define PCI_BIT_FSW 1
`define PCI_BIT_AUX_EN 0
`define PCI_BIT_ACC_EN 2
// Command codes
`define PCI_CMD_NVM_PROG 8'hA0
`define PCI_CMD_FIFO_FLUSH 8'hB0
`define PCI_CMD_SOFT_RESET 8'hB6
// Serial framing
`define PCI_BITS_PER_BYTE 3'h7
`endif

// ==== common/pci_pkg.sv ====
// Types of the control block; its bench does not refer to them.
// Assumes no other file; it does not use the constants header.
package pci_pkg;
   // Serial transaction phase, one-hot
   typedef enum logic [2:0] {
      PCI_IDLE = 3'b001,
      PCI_ADDR = 3'b010,
      PCI_DATA = 3'b100
   } pci_phase_t;
endpackage : pci_pkg

// ==== src/pci_ctrl.sv ====
// Control registers and primary serial interface of the acceleration sensor.
// Assumes one 25 MHz clock; all pins are asynchronous and are oversampled,
// so the serial clock must stay well below a quarter of the system clock.
//
// Contract
// [R1] Z-axis offset: 8-bit read-write, reset zero, copied to nonvolatile store.
// [R2] Power-save off keeps fast clock on; power config resets to 0x03.
// [R3] Power-save on runs the slow clock whenever no measurement is ongoing.
// [R4] In power-save, FIFO read blocked unless self-wakeup set and interrupt seen.
// [R5] Sensor enable resets zero; bit 2 accelerometer on, bit 0 auxiliary on.
// [R6] Command register always reads back zero.
// [R7] Program code 0xA0 copies nonvolatile-backed registers into the store.
// [R8] Flush code 0xB0 empties FIFO, leaving its configuration untouched.
// [R9] Soft-reset code 0xB6 returns every configuration setting to default.
// [R10] After reset the primary interface is an I2C target.
// [R11] Primary interface runs 4-wire SPI, or 3-wire when software selects.
// [R12] Auxiliary enabled: device masters external sensor and fetches its data.
// [R13] Both interrupt pins drive outputs by default, or act as FIFO sync inputs.
// [R14] Shared data pin: input in 4-wire, two-way in 3-wire and I2C; the code drives it only in 3-wire SPI reads, never in I2C.
// [R15] Serial-out pin: read data in 4-wire SPI, address select in I2C.
// [R16] Three-wire select bit: 0 means 4-wire, 1 means 3-wire.
// [R17] Chip-select rising edge after reset switches interface to SPI.
// [R18] Any other command code written leaves device state unchanged.
`include "pci_consts.svh"

module pci_ctrl (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_chip_select_n,
   input wire logic i_shared_clock_pin,
   input wire logic i_shared_data_pin,
   output logic o_shared_data_pin,
   output logic o_shared_data_pin_oe,
   input wire logic i_serial_out_addr_sel,
   output logic o_serial_out_addr_sel,
   output logic o_serial_out_addr_sel_oe,
   input wire logic i_irq_pin_a,
   output logic o_irq_pin_a,
   output logic o_irq_pin_a_oe,
   input wire logic i_irq_pin_b,
   output logic o_irq_pin_b,
   output logic o_irq_pin_b_oe,
   input wire logic i_irq_a_as_input,
   input wire logic i_irq_b_as_input,
   input wire logic i_irq_a_event,
   input wire logic i_irq_b_event,
   input wire logic i_meas_busy,
   output logic o_fast_clk_en,
   output logic o_fifo_read_allow,
   output logic o_acc_on,
   output logic o_aux_on,
   output logic o_aux_master_en,
   output logic o_nvm_prog,
   output logic [7:0] o_nvm_z_offset,
   output logic o_fifo_flush,
   output logic o_soft_reset,
   output logic o_spi_mode,
   output logic o_three_wire,
   output logic o_i2c_addr_sel,
   output logic o_fifo_sync_a,
   output logic o_fifo_sync_b
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [5:0] sync1_ff;
   logic [5:0] sync2_ff;
   logic cs_n_d_ff;
   logic sck_d_ff;
   logic cs_rise;
   logic cs_fall;
   logic sck_rise;
   logic sck_fall;
   logic cfg_rst;
   logic soft_rst_ff;
   logic spi_mode_ff;
   logic [7:0] if_conf_ff;
   logic [7:0] z_offset_ff;
   logic [7:0] power_configuration_ff;
   logic [7:0] sens_en_ff;
   pci_pkg::pci_phase_t phase_ff;
   logic [2:0] bit_cnt_ff;
   logic [7:0] rx_ff;
   logic [7:0] tx_ff;
   logic [6:0] addr_ff;
   logic rd_ff;
   logic out_bit_ff;
   logic wr_stb;
   logic [7:0] rx_byte;
   logic byte_done;
   logic irq_seen_ff;

   // Readback decode for the read data path; unmapped addresses read zero
   function automatic logic [7:0] rd_reg(input logic [6:0] a,
                                         input logic [7:0] ifc,
                                         input logic [7:0] zo,
                                         input logic [7:0] pc,
                                         input logic [7:0] se);
      logic [7:0] v;
      v = 8'h00;
      if (a == `PCI_ADR_IF_CONF) begin
         v = ifc;
      end else if (a == `PCI_ADR_Z_OFFSET) begin
         v = zo;
      end else if (a == `PCI_ADR_POWER_CONFIGURATION) begin
         v = pc;
      end else if (a == `PCI_ADR_SENS_EN) begin
         v = se;
      end else if (a == `PCI_ADR_CMD) begin
         v = `PCI_CMD_READ_VAL; // [R6]
      end
      return v;
   endfunction : rd_reg

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: cs, sck, data, serial-out, irq a, irq b
   // Idle-high reset of cs and sck avoids a false edge after reset.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         sync1_ff <= 6'h03;
         sync2_ff <= 6'h03;
      end else begin
         sync1_ff <= {i_irq_pin_b, i_irq_pin_a, i_serial_out_addr_sel,
                      i_shared_data_pin, i_shared_clock_pin, i_chip_select_n};
         sync2_ff <= sync1_ff;
      end
   end

   // Edge history taken from the second stage only
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         cs_n_d_ff <= 1'b1;
         sck_d_ff <= 1'b1;
      end else begin
         cs_n_d_ff <= sync2_ff[0];
         sck_d_ff <= sync2_ff[1];
      end
   end

   assign cs_rise = sync2_ff[0] & ~cs_n_d_ff;
   assign cs_fall = ~sync2_ff[0] & cs_n_d_ff;
   assign sck_rise = sync2_ff[1] & ~sck_d_ff & ~sync2_ff[0];
   assign sck_fall = ~sync2_ff[1] & sck_d_ff & ~sync2_ff[0];
   assign cfg_rst = i_rst | soft_rst_ff; // [R9]

   ////////////////////////////////////////////////////////////////////////////
   // Interface selection: I2C after any reset, SPI from the first cs rise
   always_ff @(posedge i_mclk) begin
      if (cfg_rst) begin
         spi_mode_ff <= 1'b0; // [R10]
      end else if (cs_rise) begin
         spi_mode_ff <= 1'b1; // [R17]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial engine: byte 0 is R/W plus address, then data bytes with
   // address auto-increment while cs stays low. Sampling on sck rise serves
   // both clock polarities since the engine only counts edges inside a frame.
   assign rx_byte = {rx_ff[6:0], o_three_wire && rd_ff ? 1'b0 : sync2_ff[2]};
   assign byte_done = sck_rise && (bit_cnt_ff == `PCI_BITS_PER_BYTE);
   assign wr_stb = byte_done && (phase_ff == pci_pkg::PCI_DATA) && !rd_ff
                   && spi_mode_ff;

   always_ff @(posedge i_mclk) begin
      if (cfg_rst || cs_fall || sync2_ff[0]) begin
         phase_ff <= sync2_ff[0] ? pci_pkg::PCI_IDLE : pci_pkg::PCI_ADDR;
         bit_cnt_ff <= 3'h0;
         rx_ff <= 8'h00;
         tx_ff <= 8'h00;
         addr_ff <= 7'h00;
         rd_ff <= 1'b0;
      end else if (sck_rise) begin
         bit_cnt_ff <= bit_cnt_ff + 3'h1;
         rx_ff <= rx_byte;
         if (byte_done) begin
            case (phase_ff)
               pci_pkg::PCI_ADDR: begin
                  phase_ff <= pci_pkg::PCI_DATA;
                  rd_ff <= rx_byte[7];
                  addr_ff <= rx_byte[6:0];
                  tx_ff <= 8'h00; // Dummy byte precedes read data
               end
               pci_pkg::PCI_DATA: begin
                  tx_ff <= rd_reg(addr_ff, if_conf_ff, z_offset_ff, power_configuration_ff,
                                  sens_en_ff);
                  addr_ff <= addr_ff + 7'h1;
               end
               default: ;
            endcase
         end
      end
   end

   // Read data shifts out on the falling edge, msb first
   always_ff @(posedge i_mclk) begin
      if (cfg_rst || sync2_ff[0]) begin
         out_bit_ff <= 1'b0;
      end else if (sck_fall) begin
         out_bit_ff <= tx_ff[3'h7 - bit_cnt_ff];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers, all restored by either reset
   always_ff @(posedge i_mclk) begin
      if (cfg_rst) begin
         if_conf_ff <= `PCI_RST_IF_CONF;
         power_configuration_ff <= `PCI_RST_POWER_CONFIGURATION; // [R2]
         sens_en_ff <= `PCI_RST_SENS_EN; // [R5]
         z_offset_ff <= `PCI_RST_Z_OFFSET; // [R1]
      end else if (wr_stb) begin
         if (addr_ff == `PCI_ADR_IF_CONF) begin
            if_conf_ff <= {3'h0, rx_byte[`PCI_BIT_AUX_IF], 3'h0,
                           rx_byte[`PCI_BIT_THREE_WIRE]}; // [R11] [R16]
         end else if (addr_ff == `PCI_ADR_Z_OFFSET) begin
            z_offset_ff <= rx_byte; // [R1]
         end else if (addr_ff == `PCI_ADR_POWER_CONFIGURATION) begin
            power_configuration_ff <= {6'h00, rx_byte[1:0]};
         end else if (addr_ff == `PCI_ADR_SENS_EN) begin
            sens_en_ff <= {5'h00, rx_byte[`PCI_BIT_ACC_EN], 1'b0,
                           rx_byte[`PCI_BIT_AUX_EN]}; // [R5]
         end
      end
   end

   // Command decode; pulses last one cycle, unknown codes do nothing
   always_ff @(posedge i_mclk) begin
      if (cfg_rst) begin
         o_nvm_prog <= 1'b0;
         o_fifo_flush <= 1'b0;
         soft_rst_ff <= 1'b0;
         o_soft_reset <= 1'b0;
      end else begin
         o_nvm_prog <= wr_stb && addr_ff == `PCI_ADR_CMD
                       && rx_byte == `PCI_CMD_NVM_PROG; // [R7] [R18]
         o_fifo_flush <= wr_stb && addr_ff == `PCI_ADR_CMD
                         && rx_byte == `PCI_CMD_FIFO_FLUSH; // [R8] [R18]
         soft_rst_ff <= wr_stb && addr_ff == `PCI_ADR_CMD
                        && rx_byte == `PCI_CMD_SOFT_RESET; // [R9] [R18]
         o_soft_reset <= wr_stb && addr_ff == `PCI_ADR_CMD
                         && rx_byte == `PCI_CMD_SOFT_RESET; // [R9]
      end
   end

   // Image for the nonvolatile store, valid with the program pulse
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_nvm_z_offset <= `PCI_RST_Z_OFFSET;
      end else begin
         o_nvm_z_offset <= z_offset_ff; // [R7]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power save: interrupt latch for self-wakeup; set wins over clear
   always_ff @(posedge i_mclk) begin
      if (cfg_rst) begin
         irq_seen_ff <= 1'b0;
      end else if (i_irq_a_event || i_irq_b_event) begin
         irq_seen_ff <= 1'b1;
      end else if (!power_configuration_ff[`PCI_BIT_APS]) begin
         irq_seen_ff <= 1'b0;
      end
   end

   // Clock request and FIFO read gate
   always_ff @(posedge i_mclk) begin
      if (cfg_rst) begin
         o_fast_clk_en <= 1'b0;
         o_fifo_read_allow <= 1'b0;
      end else begin
         o_fast_clk_en <= !power_configuration_ff[`PCI_BIT_APS] || i_meas_busy; // [R2] [R3]
         o_fifo_read_allow <= !power_configuration_ff[`PCI_BIT_APS]
                              || (power_configuration_ff[`PCI_BIT_FSW] && irq_seen_ff); // [R4]
      end
   end

   // Sensor and auxiliary enables
   always_ff @(posedge i_mclk) begin
      if (cfg_rst) begin
         o_acc_on <= 1'b0;
         o_aux_on <= 1'b0;
         o_aux_master_en <= 1'b0;
      end else begin
         o_acc_on <= sens_en_ff[`PCI_BIT_ACC_EN]; // [R5]
         o_aux_on <= sens_en_ff[`PCI_BIT_AUX_EN]; // [R5]
         o_aux_master_en <= if_conf_ff[`PCI_BIT_AUX_IF]
                            && sens_en_ff[`PCI_BIT_AUX_EN]; // [R12]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drivers. Drive only during the data phase of a read; the
   // I2C target framing lives elsewhere, so the data pin stays released.
   always_ff @(posedge i_mclk) begin
      if (cfg_rst) begin
         o_shared_data_pin <= 1'b0;
         o_shared_data_pin_oe <= 1'b0;
         o_serial_out_addr_sel <= 1'b0;
         o_serial_out_addr_sel_oe <= 1'b0;
         o_spi_mode <= 1'b0;
         o_three_wire <= 1'b0;
         o_i2c_addr_sel <= 1'b0;
      end else begin
         o_spi_mode <= spi_mode_ff; // [R10] [R17]
         o_three_wire <= if_conf_ff[`PCI_BIT_THREE_WIRE]; // [R16]
         o_shared_data_pin <= out_bit_ff;
         o_shared_data_pin_oe <= spi_mode_ff && if_conf_ff[`PCI_BIT_THREE_WIRE]
                                 && rd_ff && !sync2_ff[0]; // [R14]
         o_serial_out_addr_sel <= out_bit_ff;
         o_serial_out_addr_sel_oe <= spi_mode_ff && !if_conf_ff[`PCI_BIT_THREE_WIRE]
                                     && rd_ff && !sync2_ff[0]; // [R15]
         if (!spi_mode_ff) begin
            o_i2c_addr_sel <= sync2_ff[3]; // [R15]
         end
      end
   end

   // Interrupt pins: outputs by default, FIFO sync inputs when selected
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_irq_pin_a <= 1'b0;
         o_irq_pin_b <= 1'b0;
         o_irq_pin_a_oe <= 1'b0;
         o_irq_pin_b_oe <= 1'b0;
         o_fifo_sync_a <= 1'b0;
         o_fifo_sync_b <= 1'b0;
      end else begin
         o_irq_pin_a <= i_irq_a_event;
         o_irq_pin_b <= i_irq_b_event;
         o_irq_pin_a_oe <= !i_irq_a_as_input; // [R13]
         o_irq_pin_b_oe <= !i_irq_b_as_input; // [R13]
         o_fifo_sync_a <= i_irq_a_as_input && sync2_ff[4]; // [R13]
         o_fifo_sync_b <= i_irq_b_as_input && sync2_ff[5]; // [R13]
      end
   end

endmodule : pci_ctrl

// ==== test/pci_ctrl_properties.sv ====
// Port-level checks of the control block, bound into every instance.
// Assumes one system clock and a synchronous active-high reset.
module pci_ctrl_properties (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_chip_select_n,
   input wire logic i_irq_a_as_input,
   input wire logic i_irq_b_as_input,
   input wire logic i_meas_busy,
   input wire logic o_irq_pin_a_oe,
   input wire logic o_fifo_sync_b,
   input wire logic o_fast_clk_en,
   input wire logic o_nvm_prog,
   input wire logic o_fifo_flush,
   input wire logic o_soft_reset,
   input wire logic o_acc_on,
   input wire logic o_three_wire,
   input wire logic o_shared_data_pin_oe,
   input wire logic o_serial_out_addr_sel_oe,
   input wire logic o_spi_mode
);
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////
   // One clock domain, so clock and reset are given once
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);
   // Interrupt pin direction and the sync input
   irq_dir_a: assert property (i_irq_a_as_input [*2] |-> !o_irq_pin_a_oe)
      else $error("irq pin driven while used as input");
   sync_idle_a: assert property (!i_irq_b_as_input [*3] |-> !o_fifo_sync_b)
      else $error("sync output active on an output pin");
   // A measurement keeps the fast clock on in either power mode
   fast_busy_a: assert property (i_meas_busy [*2] |-> o_fast_clk_en)
      else $error("fast clock off during measurement");
   // Program strobe is single-cycle, command strobes never overlap, soft reset clears settings
   prog_pulse_a: assert property (o_nvm_prog |=> !o_nvm_prog)
      else $error("program strobe longer than one cycle");
   cmd_onehot_a: assert property ($onehot0({o_nvm_prog, o_fifo_flush, o_soft_reset}))
      else $error("two command strobes at once");
   reset_clears_a: assert property (o_soft_reset |-> ##3 (!o_acc_on && !o_three_wire))
      else $error("settings survive a soft reset");
   // Pin drivers only in the matching wiring mode and inside a frame
   four_wire_a: assert property (!o_three_wire |-> !o_shared_data_pin_oe)
      else $error("data pin driven in four-wire mode");
   sdo_drive_a: assert property (
      o_serial_out_addr_sel_oe |-> o_spi_mode && !o_three_wire)
      else $error("serial out driven outside four-wire mode");
   cs_idle_a: assert property (
      i_chip_select_n [*4] |-> !o_serial_out_addr_sel_oe && !o_shared_data_pin_oe)
      else $error("pin driven while chip select is high");
   // Main scenarios reached
   cover property (o_nvm_prog);
   cover property (o_soft_reset);
   cover property (o_shared_data_pin_oe);
endmodule : pci_ctrl_properties

bind pci_ctrl pci_ctrl_properties pci_ctrl_properties_i (.*);

// ==== test/pci_host_model.sv ====
// Host processor model: an SPI master in mode 00 on the primary pins.
// Assumes the bench calls xfer from one process at a time.
module pci_host_model (
   input wire logic i_mclk,
   input wire logic i_three_wire,
   input wire logic i_sdo_wire,
   input wire logic i_sdx_wire,
   output logic o_cs_n,
   output logic o_sck,
   output logic o_sdx,
   output logic o_sdx_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   // Six system clocks a phase; the block needs three to oversample a pin
   localparam int HALF = 6;
   ////////////////////////////////////////
   // Idle: chip select high, serial clock low and still
   initial begin
      o_cs_n = 1'b1;
      o_sck = 1'b0;
      o_sdx = 1'b0;
      o_sdx_oe = 1'b1;
   end
   // One frame MSB first; bits change after the clock falls, sampled before it rises
   task automatic xfer(input logic [23:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      @(negedge i_mclk);
      o_cs_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         o_sdx_oe = !(i_three_wire && tx[23] && i >= 8); // Let go for three-wire read data
         o_sdx = o_sdx_oe ? tx[23 - i] : ~o_sdx;
         repeat (HALF) @(negedge i_mclk);
         rx = {rx[6:0], i_three_wire ? i_sdx_wire : i_sdo_wire};
         o_sck = 1'b1;
         repeat (HALF) @(negedge i_mclk);
         o_sck = 1'b0;
      end
      repeat (HALF) @(negedge i_mclk);
      o_cs_n = 1'b1;
      o_sdx_oe = 1'b1;
      repeat (HALF) @(negedge i_mclk);
   endtask : xfer
endmodule : pci_host_model

// ==== test/tb.sv ====
// Self-checking bench: SPI host frames drive the control block's registers.
// Assumes the host model and the checker are compiled ahead of it.
`include "pci_consts.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_mclk = 1'b0, i_rst = 1'b1, i_meas_busy = 1'b0, addr_drv = 1'b1, host_d, host_oe;
   logic i_irq_a_as_input = 1'b0, i_irq_b_as_input = 1'b0, i_irq_a_event = 1'b0;
   logic i_irq_b_event = 1'b0, i_chip_select_n, i_shared_clock_pin, i_shared_data_pin;
   logic i_serial_out_addr_sel, i_irq_pin_a, i_irq_pin_b, o_shared_data_pin, o_irq_pin_b;
   logic o_shared_data_pin_oe, o_serial_out_addr_sel_oe, o_irq_pin_a, o_irq_pin_a_oe;
   logic o_irq_pin_b_oe, o_fast_clk_en, o_fifo_read_allow, o_acc_on, o_aux_on, o_aux_master_en;
   logic o_nvm_prog, o_fifo_flush, o_soft_reset, o_spi_mode, o_three_wire, o_i2c_addr_sel;
   logic o_fifo_sync_a, o_fifo_sync_b, o_serial_out_addr_sel;
   logic [7:0] o_nvm_z_offset, rx;
   int bad_count = 0, total_checks = 0, cycles = 0, n_prog = 0, n_flush = 0, n_rst = 0;
   ////////////////////////////////////////
   // Pin levels from all drivers; a released data line shows the inverse
   assign i_shared_data_pin = o_shared_data_pin_oe ? o_shared_data_pin :
                              (host_oe ? host_d : ~host_d);
   assign i_serial_out_addr_sel = o_serial_out_addr_sel_oe ? o_serial_out_addr_sel : addr_drv;
   assign i_irq_pin_a = o_irq_pin_a_oe ? o_irq_pin_a : 1'b1; // Outside sync source held high
   assign i_irq_pin_b = o_irq_pin_b_oe ? o_irq_pin_b : 1'b0;
   // 25 MHz system clock
   always #20 i_mclk = ~i_mclk;
   pci_ctrl pci_ctrl_i (.*);
   pci_host_model pci_host_model_i (.i_mclk(i_mclk), .i_three_wire(o_three_wire),
      .i_sdo_wire(i_serial_out_addr_sel), .i_sdx_wire(i_shared_data_pin),
      .o_cs_n(i_chip_select_n), .o_sck(i_shared_clock_pin), .o_sdx(host_d), .o_sdx_oe(host_oe));
   // Command strobes last one cycle, so they are tallied; a hang is cut short
   always @(posedge i_mclk) begin
      n_prog <= n_prog + (o_nvm_prog === 1'b1);
      n_flush <= n_flush + (o_fifo_flush === 1'b1);
      n_rst <= n_rst + (o_soft_reset === 1'b1);
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         bad_count++;
         report_and_stop();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic bit_chk(input logic seen, input logic exp);
      check({7'h00, seen}, {7'h00, exp});
   endtask : bit_chk
   task automatic wr(input logic [6:0] adr, input logic [7:0] d);
      pci_host_model_i.xfer({1'b0, adr, d, 8'h00}, 16, rx);
   endtask : wr
   // Reads carry a dummy byte first, so 24 bits are clocked
   task automatic rd(input logic [6:0] adr, input logic [7:0] exp);
      pci_host_model_i.xfer({1'b1, adr, 16'h0000}, 24, rx);
      check(rx, exp);
   endtask : rd
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////
   // Main sequence; inputs change on the falling clock edge
   initial begin
      repeat (8) @(negedge i_mclk);
      i_rst = 1'b0;
      i_irq_a_event = 1'b1;
      repeat (4) @(negedge i_mclk);
      bit_chk(o_spi_mode, 1'b0);
      bit_chk(o_i2c_addr_sel, 1'b1);
      bit_chk(o_fifo_read_allow, 1'b1);
      bit_chk(o_fast_clk_en, 1'b0);
      bit_chk(o_irq_pin_a, 1'b1);
      i_irq_a_event = 1'b0;
      i_meas_busy = 1'b1;
      addr_drv = 1'b0;
      repeat (4) @(negedge i_mclk);
      bit_chk(o_fast_clk_en, 1'b1);
      bit_chk(o_i2c_addr_sel, 1'b0);
      i_meas_busy = 1'b0;
      // The first frame only arms SPI mode, so its write is dropped
      wr(`PCI_ADR_Z_OFFSET, 8'h5A);
      bit_chk(o_spi_mode, 1'b1);
      // Address select is frozen once SPI mode is on
      addr_drv = 1'b1;
      rd(`PCI_ADR_Z_OFFSET, 8'h00);
      rd(`PCI_ADR_SENS_EN, 8'h00);
      rd(7'h10, 8'h00);
      bit_chk(o_i2c_addr_sel, 1'b0);
      wr(`PCI_ADR_POWER_CONFIGURATION, 8'hFF);
      rd(`PCI_ADR_POWER_CONFIGURATION, 8'h03);
      wr(`PCI_ADR_POWER_CONFIGURATION, 8'h01);
      bit_chk(o_fifo_read_allow, 1'b0);
      wr(`PCI_ADR_POWER_CONFIGURATION, 8'h00);
      bit_chk(o_fifo_read_allow, 1'b1);
      bit_chk(o_fast_clk_en, 1'b1);
      wr(`PCI_ADR_POWER_CONFIGURATION, 8'h03);
      bit_chk(o_fifo_read_allow, 1'b0);
      i_irq_b_event = 1'b1;
      repeat (3) @(negedge i_mclk);
      bit_chk(o_fifo_read_allow, 1'b1);
      bit_chk(o_irq_pin_b, 1'b1);
      i_irq_b_event = 1'b0;
      for (logic [7:0] v = 8'h01; v != 8'h00; v = v << 1) begin
         wr(`PCI_ADR_SENS_EN, v | 8'h01);
         rd(`PCI_ADR_SENS_EN, (v | 8'h01) & 8'h05);
         bit_chk(o_acc_on, v[2]);
         bit_chk(o_aux_on, 1'b1);
      end
      wr(`PCI_ADR_IF_CONF, 8'h10);
      bit_chk(o_aux_master_en, 1'b1);
      wr(`PCI_ADR_SENS_EN, 8'h04);
      bit_chk(o_aux_master_en, 1'b0);
      wr(`PCI_ADR_Z_OFFSET, 8'hA5);
      rd(`PCI_ADR_Z_OFFSET, 8'hA5);
      wr(`PCI_ADR_CMD, 8'h12);
      rd(`PCI_ADR_CMD, 8'h00);
      check(8'(n_prog + n_flush + n_rst), 8'h00);
      wr(`PCI_ADR_CMD, `PCI_CMD_NVM_PROG);
      check(8'(n_prog), 8'h01);
      check(o_nvm_z_offset, 8'hA5);
      wr(`PCI_ADR_CMD, `PCI_CMD_FIFO_FLUSH);
      check(8'(n_flush), 8'h01);
      rd(`PCI_ADR_SENS_EN, 8'h04);
      wr(`PCI_ADR_IF_CONF, 8'h01);
      bit_chk(o_three_wire, 1'b1);
      rd(`PCI_ADR_Z_OFFSET, 8'hA5);
      i_irq_a_as_input = 1'b1;
      i_irq_b_event = 1'b1;
      repeat (4) @(negedge i_mclk);
      bit_chk(o_irq_pin_a_oe, 1'b0);
      bit_chk(o_fifo_sync_a, 1'b1);
      bit_chk(o_irq_pin_b_oe, 1'b1);
      bit_chk(o_fifo_sync_b, 1'b0);
      i_irq_b_event = 1'b0;
      wr(`PCI_ADR_CMD, `PCI_CMD_SOFT_RESET);
      check(8'(n_rst), 8'h01);
      // A spare frame gives a fresh chip-select edge whatever the reset did to the mode
      wr(7'h10, 8'h00);
      rd(`PCI_ADR_Z_OFFSET, 8'h00);
      rd(`PCI_ADR_IF_CONF, 8'h00);
      rd(`PCI_ADR_POWER_CONFIGURATION, 8'h03);
      bit_chk(o_acc_on, 1'b0);
      report_and_stop();
   end
endmodule : tb
